// [breakpoint_pkg.sv]
// Purpose: Shared constants and types for the breakpoint command interpreter
// Assumes: ASCII command stream, one character per handshake
// Notes:   Values are in hundredths of an output unit
package breakpoint_pkg;

  // ************************************************************
  // Widths and table size
  // ************************************************************
  localparam int XW         = 24;                 // Digitised input width
  localparam int YW         = 32;                 // Output value width
  localparam int NUM_POINTS = 23;                 // Breakpoints besides endpoints
  localparam int PRODW      = 58;                 // (XW+1) + (YW+1)
  localparam int OUT_CHARS  = 11;                 // *, sign, 7 digits, dot, CR

  // ************************************************************
  // ASCII characters
  // ************************************************************
  localparam logic [7:0] CH_PROMPT = 8'h24;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_STAR   = 8'h2A;
  localparam logic [7:0] CH_QUERY  = 8'h3F;
  localparam logic [7:0] CH_PLUS   = 8'h2B;
  localparam logic [7:0] CH_MINUS  = 8'h2D;
  localparam logic [7:0] CH_DOT    = 8'h2E;
  localparam logic [7:0] CH_ZERO   = 8'h30;

  // ************************************************************
  // Two-letter command codes
  // ************************************************************
  localparam logic [15:0] CMD_WRITE_ENABLE        = 16'h5745;
  localparam logic [15:0] CMD_SET_LOWER_ENDPOINT  = 16'h4D4E;
  localparam logic [15:0] CMD_SET_UPPER_ENDPOINT  = 16'h4D58;
  localparam logic [15:0] CMD_STORE_TABLE_POINT   = 16'h4250;
  localparam logic [15:0] CMD_ERASE_POINT_TABLE   = 16'h4542;
  localparam logic [15:0] CMD_CLEAR_OUTPUT_OFFSET = 16'h435A;
  localparam logic [15:0] CMD_LOAD_CONFIGURATION  = 16'h5355;

  // ************************************************************
  // Register map and reset values
  // ************************************************************
  localparam logic [7:0]  OFS_ADDRESS  = 8'h00;
  localparam logic [7:0]  OFS_OFFSET   = 8'h04;
  localparam logic [7:0]  OFS_CONFIG   = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_READING  = 8'h10;
  localparam logic [7:0]  RST_ADDRESS  = 8'h31;
  localparam logic [31:0] RST_CONFIG   = 32'h3107_0182;
  localparam logic [XW-1:0] RST_UPPER_X = 24'h7F_FFFF;
  localparam logic [YW-1:0] RST_UPPER_Y = 32'h0000_2710;
  localparam logic [6:0]  MAX_READING  = 7'h7F;    // Unused high guard
  localparam logic [23:0] CLAMP_MAG    = 24'h98_967F; // 9999999 hundredths
  localparam int          DIGIT_POS    = 4;       // Digit count field position

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic signed [XW-1:0] x;
    logic signed [YW-1:0] y;
  } point_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_CMD1 = 4'h2,
    ST_CMD2 = 4'h3,
    ST_ARG  = 4'h4,
    ST_SCAN = 4'h5,
    ST_MATH = 4'h6,
    ST_DIV  = 4'h7,
    ST_SUM  = 4'h8,
    ST_CONV = 4'h9,
    ST_SEND = 4'hA
  } parse_state_t;

endpackage

// [breakpoint_interp.sv]
// Purpose: ASCII command interpreter building a piecewise-linear transfer function
// Assumes: Serial framing done outside; sample_x is the digitised input
// Notes:   Table storage is flops; nonvolatile backup is outside this block
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module breakpoint_interp #(
  parameter int NUM_POINTS = breakpoint_pkg::NUM_POINTS
) (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             reset,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Serial command characters
  input  wire logic [7:0]                       rx_data,
  input  wire logic                             rx_valid,
  output logic                                  rx_ready,
  output logic      [7:0]                       tx_data,
  output logic                                  tx_valid,
  input  wire logic                             tx_ready,
  // Measurement
  input  wire logic signed [breakpoint_pkg::XW-1:0] sample_x,
  output logic      [breakpoint_pkg::YW-1:0]    reading_out
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic is_digit(input logic [7:0] c);
    return (c >= 8'h30) && (c <= 8'h39);
  endfunction

  function automatic logic [3:0] hex_nibble(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (is_digit(c)) v = c - 8'h30;
    else if (c >= 8'h41 && c <= 8'h46) v = c - 8'h37;
    else if (c >= 8'h61 && c <= 8'h66) v = c - 8'h57;
    return v[3:0];
  endfunction

  function automatic logic [23:0] pow10(input logic [2:0] k);
    unique case (k)
      3'h0: return 24'h0F_4240;
      3'h1: return 24'h01_86A0;
      3'h2: return 24'h00_2710;
      3'h3: return 24'h00_03E8;
      3'h4: return 24'h00_0064;
      3'h5: return 24'h00_000A;
      default: return 24'h00_0001;
    endcase
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  breakpoint_pkg::parse_state_t state_reg;
  breakpoint_pkg::point_t       lower_reg, upper_reg, lo_reg, hi_reg;
  breakpoint_pkg::point_t       table_reg [NUM_POINTS];
  logic [NUM_POINTS-1:0]        valid_reg;
  logic [7:0]                   addr_reg, letter_reg;
  logic [15:0]                  cmd_reg;
  logic [31:0]                  offset_reg, config_reg, dec_reg, hex_reg;
  logic [6:0]                   idx_reg;
  logic [1:0]                   idx_cnt_reg;
  logic                         neg_reg, we_armed_reg, clr_offset_reg, found_reg;
  logic [4:0]                   scan_reg;
  logic signed [breakpoint_pkg::XW-1:0] x_reg;
  logic [breakpoint_pkg::PRODW-1:0]     quo_reg;
  logic [breakpoint_pkg::XW:0]  rem_reg, den_reg;
  logic [5:0]                   div_cnt_reg;
  logic                         res_neg_reg;
  logic [23:0]                  mag_reg;
  logic [2:0]                   digit_reg;
  logic [3:0]                   dval_reg, send_reg, len_reg;
  logic [7:0]                   out_buf [breakpoint_pkg::OUT_CHARS];
  logic [breakpoint_pkg::YW-1:0] reading_reg;

  // Combinational arithmetic for the interpolation step
  logic signed [breakpoint_pkg::XW:0] dx, dxx;
  logic signed [breakpoint_pkg::YW:0] dy;
  logic [breakpoint_pkg::XW:0]        dx_mag, dxx_mag;
  logic [breakpoint_pkg::YW:0]        dy_mag;
  logic [breakpoint_pkg::XW:0]        rem_shift;
  logic signed [33:0]                 sum_full;
  logic [31:0]                        sval;

  assign dx        = 25'(x_reg) - 25'(lo_reg.x);
  assign dxx       = 25'(hi_reg.x) - 25'(lo_reg.x);
  assign dy        = 33'(hi_reg.y) - 33'(lo_reg.y);
  assign dx_mag    = dx[24] ? 25'(-dx) : 25'(dx);
  assign dxx_mag   = dxx[24] ? 25'(-dxx) : 25'(dxx);
  assign dy_mag    = dy[32] ? 33'(-dy) : 33'(dy);
  assign rem_shift = {rem_reg[23:0], quo_reg[breakpoint_pkg::PRODW-1]};
  assign sval      = neg_reg ? 32'(-dec_reg) : dec_reg;
  // Interpolated value plus offset, quotient truncated toward the lower point
  assign sum_full  = 34'(signed'(lo_reg.y)) + 34'(signed'(offset_reg))
                   + (res_neg_reg ? -34'(quo_reg[32:0]) : 34'(quo_reg[32:0]));

  // Handshakes are combinational; data comes from the reply buffer flops
  assign rx_ready    = (state_reg <= breakpoint_pkg::ST_ARG);
  assign tx_valid    = (state_reg == breakpoint_pkg::ST_SEND);
  assign tx_data     = out_buf[send_reg];
  assign reading_out = reading_reg;
  assign pready      = 1'b1;

  // ************************************************************
  // Command parser, table and arithmetic sequencer
  // ************************************************************
  always_ff @(posedge clock) begin
    clr_offset_reg <= 1'b0;
    if (reset) begin
      state_reg    <= breakpoint_pkg::ST_IDLE;
      lower_reg    <= '0;
      upper_reg    <= {breakpoint_pkg::RST_UPPER_X, breakpoint_pkg::RST_UPPER_Y};
      lo_reg       <= '0;
      hi_reg       <= '0;
      valid_reg    <= '0;
      for (int i = 0; i < NUM_POINTS; i++) table_reg[i] <= '0;
      for (int i = 0; i < breakpoint_pkg::OUT_CHARS; i++) out_buf[i] <= 8'h00;
      letter_reg   <= 8'h00;
      cmd_reg      <= 16'h0000;
      config_reg   <= breakpoint_pkg::RST_CONFIG;
      dec_reg      <= '0;
      hex_reg      <= '0;
      idx_reg      <= '0;
      idx_cnt_reg  <= '0;
      neg_reg      <= 1'b0;
      we_armed_reg <= 1'b0;
      found_reg    <= 1'b0;
      scan_reg     <= '0;
      x_reg        <= '0;
      quo_reg      <= '0;
      rem_reg      <= '0;
      den_reg      <= '0;
      div_cnt_reg  <= '0;
      res_neg_reg  <= 1'b0;
      mag_reg      <= '0;
      digit_reg    <= '0;
      dval_reg     <= '0;
      send_reg     <= '0;
      len_reg      <= '0;
      reading_reg  <= '0;
    end else begin
      unique case (state_reg)
        breakpoint_pkg::ST_IDLE: begin
          if (rx_valid && rx_data == breakpoint_pkg::CH_PROMPT) state_reg <= breakpoint_pkg::ST_ADDR;
        end
        breakpoint_pkg::ST_ADDR: begin
          // Other modules' traffic is skipped until the next prompt
          if (rx_valid) state_reg <= (rx_data == addr_reg) ? breakpoint_pkg::ST_CMD1
                                                           : breakpoint_pkg::ST_IDLE;
        end
        breakpoint_pkg::ST_CMD1: begin
          if (rx_valid && rx_data == breakpoint_pkg::CH_CR) begin
            // Bare prompt and address: take a reading of the present input
            x_reg     <= sample_x;
            lo_reg    <= lower_reg;
            hi_reg    <= upper_reg;
            found_reg <= 1'b0;
            scan_reg  <= '0;
            state_reg <= breakpoint_pkg::ST_SCAN;
          end else if (rx_valid) begin
            letter_reg <= rx_data;
            state_reg  <= breakpoint_pkg::ST_CMD2;
          end
        end
        breakpoint_pkg::ST_CMD2: begin
          if (rx_valid) begin
            cmd_reg     <= {letter_reg, rx_data};
            dec_reg     <= '0;
            hex_reg     <= '0;
            idx_reg     <= '0;
            idx_cnt_reg <= '0;
            neg_reg     <= 1'b0;
            state_reg   <= breakpoint_pkg::ST_ARG;
          end
        end
        breakpoint_pkg::ST_ARG: begin
          if (rx_valid && rx_data != breakpoint_pkg::CH_CR) begin
            hex_reg <= {hex_reg[27:0], hex_nibble(rx_data)};
            if (rx_data == breakpoint_pkg::CH_MINUS) neg_reg <= 1'b1;
            if (is_digit(rx_data)) begin
              // The first two digits of a table point command are its index
              if (cmd_reg == breakpoint_pkg::CMD_STORE_TABLE_POINT && idx_cnt_reg < 2'd2) begin
                idx_reg     <= 7'(idx_reg * 7'd10 + 7'(rx_data - breakpoint_pkg::CH_ZERO));
                idx_cnt_reg <= idx_cnt_reg + 2'd1;
              end else begin
                dec_reg <= 32'(dec_reg * 32'd10 + 32'(rx_data - breakpoint_pkg::CH_ZERO));
              end
            end
          end else if (rx_valid) begin
            // Execute; any command other than the enable disarms it
            out_buf[0] <= breakpoint_pkg::CH_STAR;
            out_buf[1] <= breakpoint_pkg::CH_CR;
            len_reg    <= 4'd2;
            send_reg   <= '0;
            state_reg  <= breakpoint_pkg::ST_SEND;
            we_armed_reg <= (cmd_reg == breakpoint_pkg::CMD_WRITE_ENABLE);
            if (cmd_reg != breakpoint_pkg::CMD_WRITE_ENABLE && !we_armed_reg) begin
              out_buf[0] <= breakpoint_pkg::CH_QUERY;
            end else begin
              unique case (cmd_reg)
                breakpoint_pkg::CMD_WRITE_ENABLE: begin
                end
                breakpoint_pkg::CMD_SET_LOWER_ENDPOINT:
                  lower_reg <= {sample_x, sval};
                breakpoint_pkg::CMD_SET_UPPER_ENDPOINT:
                  upper_reg <= {sample_x, sval};
                breakpoint_pkg::CMD_STORE_TABLE_POINT: begin
                  // One slot rewritten in place; others untouched, no insertion
                  if (idx_cnt_reg == 2'd2 && 32'(idx_reg) < NUM_POINTS) begin
                    table_reg[5'(idx_reg)] <= {sample_x, sval};
                    valid_reg[5'(idx_reg)] <= 1'b1;
                  end else begin
                    out_buf[0] <= breakpoint_pkg::CH_QUERY;
                  end
                end
                breakpoint_pkg::CMD_ERASE_POINT_TABLE: begin
                  valid_reg <= '0;
                  for (int i = 0; i < NUM_POINTS; i++) table_reg[i] <= '0;
                end
                breakpoint_pkg::CMD_CLEAR_OUTPUT_OFFSET:
                  clr_offset_reg <= 1'b1;
                breakpoint_pkg::CMD_LOAD_CONFIGURATION:
                  config_reg <= hex_reg;
                default:
                  out_buf[0] <= breakpoint_pkg::CH_QUERY;
              endcase
            end
          end
        end
        breakpoint_pkg::ST_SCAN: begin
          // Points are in increasing input order, so the last one not above x is the floor
          if (valid_reg[scan_reg] && !found_reg) begin
            if (x_reg >= table_reg[scan_reg].x) begin
              lo_reg <= table_reg[scan_reg];
            end else begin
              hi_reg    <= table_reg[scan_reg];
              found_reg <= 1'b1;
            end
          end
          scan_reg <= scan_reg + 5'd1;
          if (32'(scan_reg) == NUM_POINTS - 1) state_reg <= breakpoint_pkg::ST_MATH;
        end
        breakpoint_pkg::ST_MATH: begin
          // A zero-width segment yields the lower point's value
          quo_reg     <= (dxx_mag == '0) ? '0 : 58'(dx_mag * dy_mag);
          den_reg     <= (dxx_mag == '0) ? 25'd1 : dxx_mag;
          res_neg_reg <= dx[24] ^ dy[32] ^ dxx[24];
          rem_reg     <= '0;
          div_cnt_reg <= '0;
          state_reg   <= breakpoint_pkg::ST_DIV;
        end
        breakpoint_pkg::ST_DIV: begin
          // Restoring divider, one quotient bit per clock
          if (rem_shift >= den_reg) begin
            rem_reg <= rem_shift - den_reg;
            quo_reg <= {quo_reg[breakpoint_pkg::PRODW-2:0], 1'b1};
          end else begin
            rem_reg <= rem_shift;
            quo_reg <= {quo_reg[breakpoint_pkg::PRODW-2:0], 1'b0};
          end
          div_cnt_reg <= div_cnt_reg + 6'd1;
          if (32'(div_cnt_reg) == breakpoint_pkg::PRODW - 1) state_reg <= breakpoint_pkg::ST_SUM;
        end
        breakpoint_pkg::ST_SUM: begin
          // Exact at a stored point: dx is zero so the point's own value comes out
          reading_reg <= sum_full[31:0];
          out_buf[0]  <= breakpoint_pkg::CH_STAR;
          out_buf[1]  <= sum_full[31] ? breakpoint_pkg::CH_MINUS : breakpoint_pkg::CH_PLUS;
          out_buf[7]  <= breakpoint_pkg::CH_DOT;
          out_buf[10] <= breakpoint_pkg::CH_CR;
          // Reply readings beyond seven digits are clamped rather than wrapped; reading_reg keeps the unclamped sum's low 32 bits
          if ((sum_full[31] ? -sum_full : sum_full) > 34'(breakpoint_pkg::CLAMP_MAG))
            mag_reg <= breakpoint_pkg::CLAMP_MAG;
          else
            mag_reg <= sum_full[31] ? 24'(-sum_full) : 24'(sum_full);
          digit_reg <= '0;
          dval_reg  <= '0;
          state_reg <= breakpoint_pkg::ST_CONV;
        end
        breakpoint_pkg::ST_CONV: begin
          // Decimal digits by repeated subtraction, most significant first
          if (mag_reg >= pow10(digit_reg)) begin
            mag_reg  <= mag_reg - pow10(digit_reg);
            dval_reg <= dval_reg + 4'd1;
          end else begin
            out_buf[(digit_reg < 3'd5) ? 4'(digit_reg) + 4'd2 : 4'(digit_reg) + 4'd3]
              <= breakpoint_pkg::CH_ZERO + 8'(dval_reg);
            dval_reg  <= '0;
            digit_reg <= digit_reg + 3'd1;
            if (digit_reg == 3'd6) begin
              len_reg   <= 4'(breakpoint_pkg::OUT_CHARS);
              send_reg  <= '0;
              state_reg <= breakpoint_pkg::ST_SEND;
            end
          end
        end
        breakpoint_pkg::ST_SEND: begin
          if (tx_ready) begin
            send_reg <= send_reg + 4'd1;
            if (send_reg == len_reg - 4'd1) state_reg <= breakpoint_pkg::ST_IDLE;
          end
        end
        default: state_reg <= breakpoint_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // APB register file
  // ************************************************************
  // Read data is captured in the setup cycle so the access phase can answer at once
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_reg   <= breakpoint_pkg::RST_ADDRESS;
      offset_reg <= '0;
      prdata     <= '0;
      pslverr    <= 1'b0;
    end else begin
      if (clr_offset_reg) offset_reg <= '0;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= '0;
        unique case (paddr)
          breakpoint_pkg::OFS_ADDRESS: prdata <= {24'h00_0000, addr_reg};
          breakpoint_pkg::OFS_OFFSET:  prdata <= offset_reg;
          breakpoint_pkg::OFS_CONFIG:  prdata <= config_reg;
          breakpoint_pkg::OFS_STATUS:  prdata <= {5'b00000, valid_reg[NUM_POINTS-1:0] == '0,
                                                  (state_reg != breakpoint_pkg::ST_IDLE),
                                                  we_armed_reg,
                                                  config_reg[breakpoint_pkg::DIGIT_POS +: 4],
                                                  20'(valid_reg)};
          breakpoint_pkg::OFS_READING: prdata <= reading_reg;
          default:                     pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pwrite && !clr_offset_reg) begin
        if (paddr == breakpoint_pkg::OFS_ADDRESS) addr_reg <= pwdata[7:0];
        if (paddr == breakpoint_pkg::OFS_OFFSET) offset_reg <= pwdata;
      end
    end
  end

endmodule

// [breakpoint_interp_properties.sv]
// Purpose: Port-level properties of the breakpoint interpreter
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every interpreter instance
`timescale 1ns/1ns
module breakpoint_interp_properties #(
  parameter int NUM_POINTS = 23
) (
  // Clock, reset and register bus
  input wire logic        clock, reset, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // Serial characters and measurement
  input wire logic [7:0]  rx_data, tx_data,
  input wire logic        rx_valid, rx_ready, tx_valid, tx_ready,
  input wire logic signed [breakpoint_pkg::XW-1:0] sample_x,
  input wire logic [breakpoint_pkg::YW-1:0] reading_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Decoded setup cycle; only these five words answer without error
  logic setup, mapped;
  assign setup  = psel && !penable;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  property p_zero_wait; psel && penable |-> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready low in access phase");
  property p_unmapped; setup && !mapped |=> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; setup && mapped |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_status_pad; setup && paddr == 8'h0C |=> prdata[31:27] == 5'h00; endproperty
  a_status_pad: assert property (p_status_pad) else $error("status spare bits set");
  property p_reply_head; $rose(tx_valid) |-> tx_data inside {8'h2A, 8'h3F}; endproperty
  a_reply_head: assert property (p_reply_head) else $error("reply head wrong");
  property p_reply_end; tx_valid && tx_ready && tx_data == 8'h0D |=> !tx_valid; endproperty
  a_reply_end: assert property (p_reply_end) else $error("reply runs past CR");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply char dropped");
  property p_busy; tx_valid |-> !rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("accepting chars while replying");
  property p_reset_idle; $past(reset) |-> !tx_valid && reading_out == 32'h0000_0000; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not cleared by reset");
endmodule
bind breakpoint_interp breakpoint_interp_properties #(.NUM_POINTS(NUM_POINTS)) u_props (.*);

// [breakpoint_host.sv]
// Purpose: Host terminal model on the serial command characters
// Assumes: Characters are handed over on ready/valid edges
// Notes:   Slow mode stalls the reply every other cycle
`timescale 1ns/1ns
module breakpoint_host (
  // Clock
  input wire logic        clock,
  // Characters to and from the interpreter
  output logic     [7:0]  rx_data,
  output logic            rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  output logic            tx_ready
);
  string rep = "";
  logic  slow = 1'b0;
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // Collect reply characters
  always @(posedge clock) begin
    if (tx_valid && tx_ready) rep = {rep, string'(tx_data)};
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
  // Send a frame; a released line shows the inverse so stale data never looks valid
  task automatic send(string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_data  <= s[i];
      rx_valid <= 1'b1;
      do @(posedge clock); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~s[s.len()-1];
  endtask
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the breakpoint interpreter
// Assumes: Host model drives the serial side, bench drives APB
// Notes:   Values are hundredths; x values are raw input codes
`timescale 1ns/1ns
module testbench;
  logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00, rx_data, tx_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, reading_out;
  logic        pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready;
  logic signed [breakpoint_pkg::XW-1:0] sample_x = 24'h00_0000;
  int n_fail = 0, checks = 0;
  always #50 clock = ~clock;
  breakpoint_interp dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .sample_x(sample_x),
    .reading_out(reading_out));
  breakpoint_host host (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One frame to module '1'; the reply is bounded by the slowest read
  task automatic cmd(string s, string exp);
    host.rep = "";
    host.send({"$1", s, "\015"});
    for (int i = 0; i < 400 && host.rep.len() < exp.len(); i++) @(posedge clock);
    checks++;
    if (host.rep != exp) begin
      n_fail++;
      $display("ERROR reply to %s expected %s seen %s", s, exp, host.rep);
    end
  endtask
  task automatic prog(string s, logic [23:0] x);
    sample_x <= x;
    cmd("WE", "*\015");
    cmd(s, "*\015");
  endtask
  task automatic rd_at(logic [23:0] x, string exp, logic [31:0] val);
    sample_x <= x;
    cmd("", exp);
    check("reading_out", val, reading_out);
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    apb(1'b0, 8'h08, 32'h0); check("config", 32'h3107_0182, rd);
    rd_at(24'h00_0000, "*+00000.00\015", 32'h0);
    cmd("EB", "?\015");
    prog("EB", 24'h00_0000);
    prog("SU31070142", 24'h00_0000);
    apb(1'b0, 8'h08, 32'h0); check("config", 32'h3107_0142, rd);
    prog("MN-00050.00", 24'h00_0000);
    prog("MX+00100.00", 24'h00_03E8);
    rd_at(24'h00_01F4, "*+00025.00\015", 32'h0000_09C4);
    prog("BP00+00100.00", 24'h00_00C8);
    rd_at(24'h00_00C8, "*+00100.00\015", 32'h0000_2710);
    rd_at(24'h00_0064, "*+00025.00\015", 32'h0000_09C4);
    host.slow = 1'b1;
    prog("BP00+00050.00", 24'h00_00C8);
    rd_at(24'h00_00C8, "*+00050.00\015", 32'h0000_1388);
    host.slow = 1'b0;
    apb(1'b1, 8'h04, 32'h0000_0064);
    rd_at(24'h00_00C8, "*+00051.00\015", 32'h0000_13EC);
    apb(1'b0, 8'h0C, 32'h0); check("status", 32'h0040_0001, rd);
    prog("CZ", 24'h00_00C8);
    rd_at(24'h00_00C8, "*+00050.00\015", 32'h0000_1388);
    apb(1'b0, 8'h04, 32'h0); check("offset", 32'h0, rd);
    cmd("WE", "*\015");
    cmd("BP23+00001.00", "?\015");
    prog("BP22+00001.00", 24'h00_0384);
    prog("EB", 24'h00_00C8);
    rd_at(24'h00_00C8, "*-00020.00\015", 32'hFFFF_F830);
    apb(1'b0, 8'h0C, 32'h0); check("status", 32'h0440_0000, rd);
    apb(1'b1, 8'h20, 32'h1234_5678); check("slverr", 32'h1, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0); check("unmapped", 32'h0, rd);
    wrap_up();
  end
endmodule
